// ---- include/ov_resp_pkg.sv ----
package ov_resp_pkg;
   // command codes of the two settings held here
   localparam logic [7:0] CODE_OV_ACTION = 8'h41;
   localparam logic [7:0] CODE_OV_WARN = 8'h42;
   // field positions of the fault action byte
   localparam int ACT_SEL_HI = 7;
   localparam int ACT_SEL_LO = 6;
   localparam int LIMIT_HI = 5;
   localparam int LIMIT_LO = 3;
   localparam int MULT_HI = 2;
   localparam int MULT_LO = 0;
   // action select encodings
   localparam logic [1:0] SEL_IGNORE = 2'h0;
   localparam logic [1:0] SEL_BAD = 2'h3;
   // restart limit and hiccup multiplier encodings
   localparam logic [2:0] LIMIT_NONE = 3'h0;
   localparam logic [2:0] LIMIT_FOREVER = 3'h7;
   localparam logic [2:0] MULT_ZERO = 3'h0;
   localparam logic [2:0] MULT_ONE = 3'h1;
   // power-up contents, normally restored from non-volatile memory
   localparam logic [7:0] ACTION_RESET = 8'h80;
   localparam logic [15:0] WARN_RESET = 16'h0233;
   localparam logic [6:0] PCT_RESET = 7'h6E;
   // warning level range, percent of target
   localparam logic [6:0] PCT_MIN = 7'h67;
   localparam logic [6:0] PCT_MAX = 7'h74;
   localparam logic [6:0] PCT_SCALE = 7'h64;
   // relative format: 2^9 counts equal 100 percent
   localparam int REL_SHIFT = 9;
   localparam logic [22:0] REL_ROUND = 23'h0001FF;
   // widths
   localparam int RISE_W = 20;
   localparam int HIC_W = 23;
   // fault response sequencer states
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RISING,
      ST_CONFIRM,
      ST_RUN,
      ST_HICCUP,
      ST_LATCHED
   } seq_state_e;
endpackage : ov_resp_pkg

// ---- core/bit_sync.sv ----
`timescale 1ns/1ps
// two flip-flop level synchroniser, one lane per bit
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // destination clock
   input wire logic rstn, // async reset, active low
   input wire logic [WIDTH-1:0] async_in, // level from the other domain
   output logic [WIDTH-1:0] sync_out // synchronised level
);
   logic [WIDTH-1:0] meta_reg; // first stage, read only by second
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_next;

   // next values: plain shift
   always_comb
   begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // register stages
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_out <= sync_next;
      end
   end
endmodule : bit_sync

// ---- core/warn_limit_map.sv ----
`timescale 1ns/1ps
// maps a written warning word to a supported percent of the target
module warn_limit_map (
   input wire logic [15:0] limit_word, // word as written
   input wire logic relative_mode, // 1: relative format, 0: absolute
   input wire logic [15:0] vout_target, // present target, absolute units
   output logic [6:0] pct, // supported level, percent
   output logic ok // word maps inside the range
);
   logic [22:0] scaled; // word times one hundred
   logic [22:0] quot; // percent, rounded up

   // percent conversion, rounding up in both formats
   always_comb
   begin
      scaled = 23'(limit_word) * 23'(ov_resp_pkg::PCT_SCALE);
      quot = '0;
      ok = 1'b0;
      if (relative_mode)
      begin
         quot = (scaled + ov_resp_pkg::REL_ROUND) >> ov_resp_pkg::REL_SHIFT;
         ok = 1'b1;
      end
      else if (vout_target != 16'h0000)
      begin
         quot = (scaled + 23'(vout_target) - 23'h000001) / 23'(vout_target);
         ok = 1'b1;
      end
      // above the top level nothing fits: invalid data
      if (quot > 23'(ov_resp_pkg::PCT_MAX))
         ok = 1'b0;
      // below the bottom level rounds up to the bottom level
      if (quot < 23'(ov_resp_pkg::PCT_MIN))
         pct = ov_resp_pkg::PCT_MIN;
      else
         pct = quot[6:0];
   end
endmodule : warn_limit_map

// ---- core/ov_response_core.sv ----
`timescale 1ns/1ps
// Contract
// - fault sets status byte, word, vout bits, alerts
// - select bits 7:6 ignore, shutdown, 11b invalid
// - restart limit zero latches off immediately
// - limits 1-6 hiccup then retry, then latch
// - limit 7 retries without end
// - hiccup period is multiplier times rise time, multiplier zero as one
// - unsupported writes flag invalid data, alert
// - clean rise plus one rise time clears counter
// - ignore mode refuses start with fault present
// - warning crossing sets word, vout bits, alerts
// - warning tracks target, stored word untouched
// - warning rounds up, 103 to 116 percent
// - warning word converted per format mode
// - code 41h is a byte-wide register
// - code 42h is a word-wide register
module ov_response_core (
   input wire logic ref_clk, // core clock, 125 MHz
   input wire logic rstn, // async reset, active low
   input wire logic link_clk, // bus clock
   input wire logic link_wr_stb, // write transaction complete, pulse
   input wire logic link_rd_stb, // read transaction request, pulse
   input wire logic [7:0] link_code, // command code
   input wire logic link_word, // 1: word transaction, 0: byte
   input wire logic [15:0] link_wdata, // write data
   output logic [15:0] link_rdata, // read data
   output logic link_rvalid, // read data valid, pulse
   output logic link_busy, // write still crossing to the core
   input wire logic ov_fault_pin, // fault comparator, asynchronous
   input wire logic output_enable_pin, // output on command, asynchronous
   input wire logic relative_mode, // format mode from core logic
   input wire logic [15:0] vout_target, // target voltage
   input wire logic [15:0] vout_sense, // sensed voltage, same units
   input wire logic [19:0] rise_cycles, // programmed rise time in cycles
   input wire logic status_clear, // clear sticky status, pulse
   output logic power_enable, // converter switching allowed
   output logic status_ov_fault, // status byte overvoltage fault
   output logic status_vout, // status word vout summary
   output logic status_ov_fault_status_bit, // vout status fault bit
   output logic status_ov_warning_threshold_field, // vout status warning bit
   output logic status_invalid_data, // invalid data received
   output logic host_alert, // notify host, active high
   output logic [2:0] restart_count, // failed restart attempts
   output logic [6:0] ov_warn_pct // active warning level, percent
);
   ////////////////////////////////////////////////////////////////////////
   // link domain: capture, handshake out, shadow for reads
   logic req_tog_reg, req_tog_next; // toggles per accepted write
   logic [7:0] hold_code_reg, hold_code_next; // held command code
   logic hold_word_reg, hold_word_next; // held transaction size
   logic [15:0] hold_data_reg, hold_data_next; // held write data
   logic ack_seen_reg, ack_seen_next; // last ack level consumed
   logic [7:0] sh_action_reg, sh_action_next; // read copy of 41h
   logic [15:0] sh_warn_reg, sh_warn_next, rdata_next; // 42h copy, answer
   logic rvalid_next, busy_next, ack_sync; // strobe, busy, ack in link
   logic ack_tog_reg, ack_tog_next; // core ack, read after crossing only
   logic [7:0] action_reg, action_next; // overvolt_fault_action
   logic [15:0] warn_reg, warn_next; // overvolt_warning_threshold
   bit_sync #(.WIDTH(1)) u_ack_sync (.clk(link_clk), .rstn(rstn),
      .async_in(ack_tog_reg), .sync_out(ack_sync));
   // link next state; a write while busy is dropped
   always_comb
   begin
      req_tog_next = req_tog_reg;
      hold_code_next = hold_code_reg;
      hold_word_next = hold_word_reg;
      hold_data_next = hold_data_reg;
      ack_seen_next = ack_seen_reg;
      sh_action_next = sh_action_reg;
      sh_warn_next = sh_warn_reg;
      rdata_next = 16'h0000;
      rvalid_next = 1'b0;
      if (ack_sync != ack_seen_reg) // core values stand till next write
      begin
         ack_seen_next = ack_sync;
         sh_action_next = action_reg;
         sh_warn_next = warn_reg;
      end
      if (link_wr_stb && (req_tog_reg == ack_seen_reg))
      begin
         hold_code_next = link_code;
         hold_word_next = link_word;
         hold_data_next = link_wdata;
         req_tog_next = ~req_tog_reg;
      end
      if (link_rd_stb)
      begin
         rvalid_next = 1'b1;
         if (link_code == ov_resp_pkg::CODE_OV_ACTION)
            rdata_next = {8'h00, sh_action_reg};
         else if (link_code == ov_resp_pkg::CODE_OV_WARN)
            rdata_next = sh_warn_reg;
      end
      busy_next = (req_tog_next != ack_seen_next);
   end
   // link registers
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         req_tog_reg <= 1'b0;
         hold_code_reg <= 8'h00;
         hold_word_reg <= 1'b0;
         hold_data_reg <= 16'h0000;
         ack_seen_reg <= 1'b0;
         sh_action_reg <= ov_resp_pkg::ACTION_RESET;
         sh_warn_reg <= ov_resp_pkg::WARN_RESET;
         link_rdata <= 16'h0000;
         link_rvalid <= 1'b0;
         link_busy <= 1'b0;
      end
      else
      begin
         req_tog_reg <= req_tog_next;
         hold_code_reg <= hold_code_next;
         hold_word_reg <= hold_word_next;
         hold_data_reg <= hold_data_next;
         ack_seen_reg <= ack_seen_next;
         sh_action_reg <= sh_action_next;
         sh_warn_reg <= sh_warn_next;
         link_rdata <= rdata_next;
         link_rvalid <= rvalid_next;
         link_busy <= busy_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // core domain: register writes
   logic req_sync, fault_sync, enable_sync; // write toggle, pins, synced
   logic [6:0] pct_reg, pct_next, map_pct; // mapped level, mapper result
   logic map_ok, wr_event, invalid_event; // word fits, write, refused
   bit_sync #(.WIDTH(3)) u_core_sync (.clk(ref_clk), .rstn(rstn),
      .async_in({req_tog_reg, ov_fault_pin, output_enable_pin}),
      .sync_out({req_sync, fault_sync, enable_sync}));
   warn_limit_map u_map (.limit_word(hold_data_reg),
      .relative_mode(relative_mode), .vout_target(vout_target),
      .pct(map_pct), .ok(map_ok));
   // decode a crossed write; hold regs are stable while it is pending
   always_comb
   begin
      wr_event = (req_sync != ack_tog_reg);
      ack_tog_next = req_sync;
      action_next = action_reg;
      warn_next = warn_reg;
      pct_next = pct_reg;
      invalid_event = 1'b0;
      if (wr_event && (hold_code_reg == ov_resp_pkg::CODE_OV_ACTION))
      begin
         if (hold_word_reg || (hold_data_reg[ov_resp_pkg::ACT_SEL_HI:
             ov_resp_pkg::ACT_SEL_LO] == ov_resp_pkg::SEL_BAD))
            invalid_event = 1'b1;
         else
            action_next = hold_data_reg[7:0]; // takes effect at once
      end
      else if (wr_event && (hold_code_reg == ov_resp_pkg::CODE_OV_WARN))
      begin
         if (!hold_word_reg || !map_ok)
            invalid_event = 1'b1;
         else
         begin
            warn_next = hold_data_reg; // stored word kept as written
            pct_next = map_pct;
         end
      end
   end
   // register file
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack_tog_reg <= 1'b0;
         action_reg <= ov_resp_pkg::ACTION_RESET;
         warn_reg <= ov_resp_pkg::WARN_RESET;
         pct_reg <= ov_resp_pkg::PCT_RESET;
      end
      else
      begin
         ack_tog_reg <= ack_tog_next;
         action_reg <= action_next;
         warn_reg <= warn_next;
         pct_reg <= pct_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // core domain: fault response sequencer
   ov_resp_pkg::seq_state_e state_reg, state_next;
   logic [22:0] timer_reg, timer_next; // cycles in timed states
   logic [2:0] count_reg, count_next; // failed restart attempts
   logic attempt_reg, attempt_next, shut_fault, fault_event; // retry, fault
   logic [1:0] sel; // action select field
   logic [2:0] limit, mult; // restart limit, hiccup multiplier fields
   logic [22:0] hiccup_len, rise_len; // hiccup period, rise time (>= 1)
   // hiccup and rise lengths from the fields
   always_comb
   begin
      sel = action_reg[ov_resp_pkg::ACT_SEL_HI:ov_resp_pkg::ACT_SEL_LO];
      limit = action_reg[ov_resp_pkg::LIMIT_HI:ov_resp_pkg::LIMIT_LO];
      mult = action_reg[ov_resp_pkg::MULT_HI:ov_resp_pkg::MULT_LO];
      rise_len = (rise_cycles == '0) ? 23'h000001 : 23'(rise_cycles);
      hiccup_len = rise_len * 23'((mult == ov_resp_pkg::MULT_ZERO) ?
         ov_resp_pkg::MULT_ONE : mult);
      shut_fault = fault_sync && (sel != ov_resp_pkg::SEL_IGNORE);
   end
   // sequencer next state
   always_comb
   begin
      state_next = state_reg;
      timer_next = timer_reg + 23'h000001;
      count_next = count_reg;
      attempt_next = attempt_reg;
      case (state_reg)
         ov_resp_pkg::ST_OFF:
         begin
            timer_next = '0;
            count_next = '0;
            attempt_next = 1'b0;
            if (enable_sync && !fault_sync) // fault at enable blocks start
               state_next = ov_resp_pkg::ST_RISING;
         end
         ov_resp_pkg::ST_RISING, ov_resp_pkg::ST_CONFIRM, ov_resp_pkg::ST_RUN:
         begin
            if (shut_fault)
            begin
               timer_next = '0;
               if (limit == ov_resp_pkg::LIMIT_NONE)
                  state_next = ov_resp_pkg::ST_LATCHED;
               else if (!attempt_reg || (limit == ov_resp_pkg::LIMIT_FOREVER))
                  state_next = ov_resp_pkg::ST_HICCUP;
               else
               begin
                  count_next = count_reg + 3'h1;
                  if (count_reg + 3'h1 >= limit)
                     state_next = ov_resp_pkg::ST_LATCHED;
                  else
                     state_next = ov_resp_pkg::ST_HICCUP;
               end
            end
            else if ((state_reg != ov_resp_pkg::ST_RUN) &&
                     (timer_reg + 23'h000001 >= rise_len))
            begin
               timer_next = '0;
               if (state_reg == ov_resp_pkg::ST_RISING)
                  state_next = ov_resp_pkg::ST_CONFIRM;
               else
               begin
                  state_next = ov_resp_pkg::ST_RUN;
                  count_next = '0;
                  attempt_next = 1'b0;
               end
            end
         end
         ov_resp_pkg::ST_HICCUP:
         begin
            if (timer_reg + 23'h000001 >= hiccup_len)
            begin
               timer_next = '0;
               attempt_next = 1'b1;
               state_next = ov_resp_pkg::ST_RISING;
            end
         end
         ov_resp_pkg::ST_LATCHED: timer_next = '0;
         default: state_next = ov_resp_pkg::ST_OFF;
      endcase
      if (!enable_sync) // commanded off wins and clears the latch
         state_next = ov_resp_pkg::ST_OFF;
   end
   // sequencer registers
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= ov_resp_pkg::ST_OFF;
         timer_reg <= '0;
         count_reg <= '0;
         attempt_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         count_reg <= count_next;
         attempt_reg <= attempt_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // core domain: status flags and outputs
   logic fault_prev_reg, warn_prev_reg, warn_above, warn_event; // edges
   logic [22:0] warn_lhs, warn_rhs; // sensed times 100, target times level
   logic ovf_next, ovw_next, inv_next, byte_next, word_next;
   // events and sticky bits; a set in the clear cycle wins
   always_comb
   begin
      warn_lhs = 23'(vout_sense) * 23'(ov_resp_pkg::PCT_SCALE);
      warn_rhs = 23'(vout_target) * 23'(pct_reg);
      warn_above = (warn_lhs > warn_rhs);
      warn_event = warn_above && !warn_prev_reg;
      fault_event = fault_sync && !fault_prev_reg;
      byte_next = (status_ov_fault && !status_clear) || fault_event;
      ovf_next = (status_ov_fault_status_bit && !status_clear) || fault_event;
      ovw_next = (status_ov_warning_threshold_field && !status_clear) || warn_event;
      inv_next = (status_invalid_data && !status_clear) || invalid_event;
      word_next = ovf_next || ovw_next;
   end
   // status and output registers
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fault_prev_reg <= 1'b0;
         warn_prev_reg <= 1'b0;
         status_ov_fault <= 1'b0;
         status_vout <= 1'b0;
         status_ov_fault_status_bit <= 1'b0;
         status_ov_warning_threshold_field <= 1'b0;
         status_invalid_data <= 1'b0;
         host_alert <= 1'b0;
         power_enable <= 1'b0;
         restart_count <= '0;
         ov_warn_pct <= ov_resp_pkg::PCT_RESET;
      end
      else
      begin
         fault_prev_reg <= fault_sync;
         warn_prev_reg <= warn_above;
         status_ov_fault <= byte_next;
         status_vout <= word_next;
         status_ov_fault_status_bit <= ovf_next;
         status_ov_warning_threshold_field <= ovw_next;
         status_invalid_data <= inv_next;
         host_alert <= byte_next || word_next || inv_next;
         power_enable <= state_next inside {ov_resp_pkg::ST_RISING,
            ov_resp_pkg::ST_CONFIRM, ov_resp_pkg::ST_RUN};
         restart_count <= count_next;
         ov_warn_pct <= pct_next;
      end
   end
endmodule : ov_response_core

// ---- tb/pmbus_host_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// bus host model; its clock runs only within transfers and the two ticks in reset
module pmbus_host_model (
   input wire logic link_busy, // write crossing
   input wire logic link_rvalid, // read valid
   input wire logic [15:0] link_rdata, // read data
   output logic link_clk, // bus clock, idle low
   output logic link_wr_stb, // write done
   output logic link_rd_stb, // read request
   output logic [7:0] link_code, // command code
   output logic link_word, // word size
   output logic [15:0] link_wdata // write data
);
   // fault limit lies outside
   initial
   begin
      {link_clk, link_wr_stb, link_rd_stb} = 3'h0;
      {link_code, link_word, link_wdata} = 25'h0;
   end
   // one bus period
   task automatic tick();
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
   endtask : tick
   // released lines flip so a stale value never reads as held
   task automatic drop();
      {link_wr_stb, link_rd_stb} = 2'h0;
      {link_code, link_word, link_wdata} = ~{link_code, link_word, link_wdata};
   endtask : drop
   // byte or word write, clocked on until the crossing clears
   task automatic write(input logic [7:0] c, input logic w,
                        input logic [15:0] d);
      #3;
      {link_code, link_word, link_wdata, link_wr_stb} = {c, w, d, 1'b1};
      tick();
      drop();
      tick();
      for (int n = 0; n < 40 && link_busy !== 1'b0; n++)
         tick();
   endtask : write
   // read; answer stands from the taking edge to the next one
   task automatic read(input logic [7:0] c, output logic [15:0] d);
      #3;
      {link_code, link_rd_stb} = {c, 1'b1};
      tick();
      drop();
      d = (link_rvalid === 1'b1) ? link_rdata : 16'hBAD0;
      tick();
   endtask : read
endmodule : pmbus_host_model

// ---- tb/ov_response_asserts.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// port checker of the fault response block
module ov_response_asserts (
   input wire logic ref_clk, // core clock
   input wire logic rstn, // reset, active low
   input wire logic link_clk, // bus clock
   input wire logic link_rd_stb, // read request
   input wire logic [15:0] link_rdata, // read data
   input wire logic link_rvalid, // read valid
   input wire logic status_clear, // sticky clear
   input wire logic status_ov_fault, // fault bit
   input wire logic status_vout, // vout summary
   input wire logic status_ov_fault_status_bit, // vout fault
   input wire logic status_ov_warning_threshold_field, // vout warning
   input wire logic status_invalid_data, // bad data
   input wire logic host_alert, // host notify
   input wire logic [2:0] restart_count, // retries
   input wire logic [6:0] ov_warn_pct // warning level
);
   // a lone request, then one valid cycle and quiet
   sequence s_lone_read;
      link_rd_stb ##1 !link_rd_stb;
   endsequence
   sequence s_answer;
      link_rvalid ##1 !link_rvalid;
   endsequence
   a_read_answer:
   assert property (@(posedge link_clk) disable iff (!rstn)
      s_lone_read |-> s_answer) else $error("read answer");
   a_rdata_quiet:
   assert property (@(posedge link_clk) disable iff (!rstn)
      !link_rvalid |-> link_rdata == 16'h0000) else $error("rdata idle");
   a_fault_bits:
   assert property (@(posedge ref_clk) disable iff (!rstn)
      status_ov_fault_status_bit |-> status_vout && status_ov_fault) else $error("ovf");
   a_warn_bits:
   assert property (@(posedge ref_clk) disable iff (!rstn)
      status_ov_warning_threshold_field |-> status_vout) else $error("ovw");
   a_alert_sum:
   assert property (@(posedge ref_clk) disable iff (!rstn)
      status_vout || status_ov_fault || status_invalid_data |-> host_alert)
      else $error("alert");
   a_fault_sticky:
   assert property (@(posedge ref_clk) disable iff (!rstn)
      status_ov_fault && !status_clear |=> status_ov_fault)
      else $error("sticky");
   a_pct_range:
   assert property (@(posedge ref_clk) disable iff (!rstn)
      ov_warn_pct >= ov_resp_pkg::PCT_MIN &&
      ov_warn_pct <= ov_resp_pkg::PCT_MAX)
      else $error("pct");
   a_count_step:
   assert property (@(posedge ref_clk) disable iff (!rstn)
      $changed(restart_count) |->
      restart_count == $past(restart_count) + 3'h1 || restart_count == 3'h0)
      else $error("count");
endmodule : ov_response_asserts

bind ov_response_core ov_response_asserts chk (.*);

// ---- tb/tb.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// bench for the overvoltage fault response block
`define check_eq(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module tb;
   logic ref_clk, rstn, ov_fault_pin, output_enable_pin, relative_mode;
   logic status_clear, link_clk, link_wr_stb, link_rd_stb, link_word;
   logic link_rvalid, link_busy, power_enable, status_ov_fault, host_alert;
   logic status_vout, status_ov_fault_status_bit, status_ov_warning_threshold_field, status_invalid_data;
   logic [15:0] vout_target, vout_sense, link_wdata, link_rdata, rd, wv;
   logic [19:0] rise_cycles; // rise time, shortened
   logic [7:0] link_code, act; // code, action byte
   logic [2:0] restart_count; // retries
   logic [6:0] ov_warn_pct, p; // warning levels
   logic [31:0] rnd_reg = 32'h8B28; // lfsr state
   int num_errors = 0;
   int comparisons = 0;
   int lo, e; // hiccup gap, measured and expected
   logic [24:0] bad [4] = '{25'h8200C5, 25'h830048, 25'h840210, 25'h850252};
   ov_response_core dut (.*);
   pmbus_host_model host (.*);
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // relative word to percent, rounded up, floored at the lowest level
   function automatic logic [6:0] exp_pct(input logic [15:0] w);
      logic [22:0] q;
      q = ({7'h00, w} * 23'h000064 + 23'h0001FF) >> 9;
      return (q < 23'h000067) ? ov_resp_pkg::PCT_MIN : q[6:0];
   endfunction : exp_pct
   task automatic results();
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task automatic clear_status();
      @(negedge ref_clk);
      status_clear = 1'b1;
      @(negedge ref_clk);
      status_clear = 1'b0;
   endtask : clear_status
   // program, start clean, raise the fault for hold cycles, time the gap
   task automatic fault_run(input logic [7:0] a, input int hold);
      int seen;
      host.write(ov_resp_pkg::CODE_OV_ACTION, 1'b0, {8'h00, a});
      @(negedge ref_clk);
      {output_enable_pin, ov_fault_pin} = 2'h0;
      clear_status();
      repeat (6) @(negedge ref_clk);
      output_enable_pin = 1'b1;
      repeat (24) @(negedge ref_clk);
      ov_fault_pin = 1'b1;
      lo = 0;
      seen = 0;
      for (int i = 0; i < 300; i++)
      begin
         @(negedge ref_clk);
         if (i == hold)
            ov_fault_pin = 1'b0;
         if (power_enable === 1'b0 && seen < 2)
            {seen, lo} = {32'd1, lo + 1};
         else if (seen == 1)
            seen = 2;
      end
   endtask : fault_run
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rstn, ov_fault_pin, output_enable_pin, status_clear} = 4'h0;
      {relative_mode, vout_target, vout_sense} = {1'b1, 16'h03E8, 16'h0000};
      rise_cycles = 20'h00004;
      repeat (3) @(negedge ref_clk);
      host.tick();
      host.tick();
      @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      `check_eq(ov_warn_pct, ov_resp_pkg::PCT_RESET)
      host.read(ov_resp_pkg::CODE_OV_ACTION, rd);
      `check_eq(rd, {8'h00, ov_resp_pkg::ACTION_RESET})
      host.read(ov_resp_pkg::CODE_OV_WARN, rd);
      `check_eq(rd, ov_resp_pkg::WARN_RESET)
      repeat (4)
      begin
         rnd_reg = lfsr(rnd_reg);
         act = {rnd_reg[8], ~rnd_reg[8], rnd_reg[5:0]};
         host.write(ov_resp_pkg::CODE_OV_ACTION, 1'b0, {8'h00, act});
         host.read(ov_resp_pkg::CODE_OV_ACTION, rd);
         `check_eq(rd, {8'h00, act})
      end
      // refused writes flag and alert
      for (int k = 0; k < 4; k++)
      begin
         clear_status();
         host.write(bad[k][24:17], bad[k][16], bad[k][15:0]);
         repeat (4) @(negedge ref_clk);
         `check_eq({status_invalid_data, host_alert}, 2'h3)
      end
      host.read(ov_resp_pkg::CODE_OV_ACTION, rd);
      `check_eq(rd, {8'h00, act})
      // relative limits: both corners, then random
      for (int k = 0; k < 5; k++)
      begin
         rnd_reg = lfsr(rnd_reg);
         wv = 16'h0200 + {9'h000, rnd_reg[6:0] % 7'h52};
         wv = (k == 0) ? 16'h0200 : (k == 1) ? 16'h0251 : wv;
         host.write(ov_resp_pkg::CODE_OV_WARN, 1'b1, wv);
         repeat (4) @(negedge ref_clk);
         `check_eq(ov_warn_pct, exp_pct(wv))
         host.read(ov_resp_pkg::CODE_OV_WARN, rd);
         `check_eq(rd, wv)
      end
      // at the level stays quiet, one count above warns
      p = exp_pct(wv);
      clear_status();
      vout_sense = {9'h000, p} * 16'h000A;
      repeat (4) @(negedge ref_clk);
      `check_eq(status_ov_warning_threshold_field, 1'b0)
      vout_sense = vout_sense + 16'h0001;
      repeat (4) @(negedge ref_clk);
      `check_eq({status_ov_warning_threshold_field, status_vout, host_alert}, 3'h7)
      {vout_sense, relative_mode} = {16'h0000, 1'b0};
      host.write(ov_resp_pkg::CODE_OV_WARN, 1'b1, 16'h0451);
      @(negedge ref_clk);
      vout_target = 16'h07D0;
      repeat (4) @(negedge ref_clk);
      `check_eq(ov_warn_pct, 7'h6F)
      host.read(ov_resp_pkg::CODE_OV_WARN, rd);
      `check_eq(rd, 16'h0451)
      @(negedge ref_clk);
      {vout_target, relative_mode} = {16'h03E8, 1'b1};
      fault_run(8'h80, 3);
      `check_eq({power_enable, restart_count}, 4'h0)
      `check_eq({status_ov_fault, status_vout, status_ov_fault_status_bit}, 3'h7)
      fault_run(8'h91, 999);
      `check_eq({power_enable, restart_count}, 4'h2)
      fault_run(8'h7B, 150);
      `check_eq({power_enable, restart_count}, 4'h8)
      for (int m = 0; m < 8; m++)
      begin
         fault_run(8'h48 | 8'(m), 2);
         e = (m == 0) ? 4 : 4 * m;
         `check_eq(lo >= e && lo <= e + 1, 1'b1)
         `check_eq({power_enable, restart_count}, 4'h8)
      end
      fault_run(8'h00, 999);
      `check_eq({power_enable, status_ov_fault}, 2'h3)
      `check_eq(lo, 0)
      output_enable_pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      output_enable_pin = 1'b1;
      repeat (24) @(negedge ref_clk);
      `check_eq(power_enable, 1'b0)
      ov_fault_pin = 1'b0;
      repeat (24) @(negedge ref_clk);
      `check_eq(power_enable, 1'b1)
      results();
   end
   // watchdog far past the expected run length
   initial
   begin
      #200000;
      num_errors++;
      results();
   end
endmodule : tb
